// file: inc/tpi_cfg.svh
`ifndef TPI_CFG_SVH
`define TPI_CFG_SVH
// What this block does
// - high vector 0008h, low vector 0018h
// - high request preempts running low routine
// - each source has flag, enable, priority; line0 has no priority bit, fixed high
// - priority mode bit 7, clear at reset
// - bit 7 enables high, bit 6 low
// - pending enabled source vectors by priority
// - priority bits ignored in compatibility mode
// - compat: bit 6 peripherals, bit 7 all
// - compat: every interrupt goes to 0008h
// - taking interrupt clears governing global enable
// - no low service during high routine
// - vectoring pushes return address, loads vector
// - return instruction sets governing enable again
// - pin event latency three to four cycles
// - flags set regardless of any enable
// - bit 7 zero disables all interrupts
// - bit 6 gates peripheral or low sources
// - bits 5,4,3 enable timer, line0, port
// - bits 2,1 sticky timer and line0 flags
// - bit 0 sticky port mismatch flag; mismatch keeps setting it until a port read

`define TPI_PC_W       21
`define TPI_VEC_HI     21'h0_0008
`define TPI_VEC_LO     21'h0_0018
`define TPI_INSTR_DIV  4
`define TPI_IRQ_LAT    3
`define TPI_NSRC       11
`define TPI_PERIPH_MSK 11'h7f8
`define TPI_RST_BYTE   8'h00
`define TPI_RST_WORD   32'h0000_0000

`define TPI_IDX_CTRL   6'h00
`define TPI_IDX_RESET_CONTROL_REG   6'h01
`define TPI_IDX_PFLG   6'h02
`define TPI_IDX_PEN    6'h03
`define TPI_IDX_PPRI   6'h04
`define TPI_IDX_CPRI   6'h05
`define TPI_IDX_STAT   6'h06
`define TPI_IDX_PORT_B_INPUT_REG  6'h07

`define TPI_B_HIGH_LEVEL_GLOBAL_ENABLE     7
`define TPI_B_LOW_LEVEL_GLOBAL_ENABLE     6
`define TPI_B_T0IE     5
`define TPI_B_I0IE     4
`define TPI_B_PORT_B_CHANGE_IRQ_ENABLE     3
`define TPI_B_T0IF     2
`define TPI_B_I0IF     1
`define TPI_B_PORT_B_CHANGE_IRQ_FLAG     0
`define TPI_B_MODE     7
`define TPI_B_CPRI_T0  1
`define TPI_B_CPRI_RB  0
`endif

// file: inc/tpi_pkg.sv
package tpi_pkg;
   typedef enum logic [1:0] {
      TPI_IDLE = 2'h0,
      TPI_WAIT = 2'h1,
      TPI_VECT = 2'h2
   } tpi_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] idx;
      logic [7:0] wdat;
   } tpi_acc_t;

   typedef struct packed {
      logic hi;
      logic lo;
      logic any;
   } tpi_req_t;
endpackage : tpi_pkg

// file: rtl/tpi_wb_slave.sv
`timescale 1ns/1ps
`include "tpi_cfg.svh"
module tpi_wb_slave
   import tpi_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic             wb_ack_o,
   output logic [31:0]      wb_dat_o,
   // register side
   input  wire logic [7:0]  rd_data_i,
   output tpi_acc_t         acc_o
);
   logic req;
   logic ack_r;

   assign req      = wb_cyc_i && wb_stb_i;
   assign wb_ack_o = ack_r;
   // write lands on the edge the master sees ack
   assign acc_o.wr   = req && wb_we_i && ack_r && wb_sel_i[0];
   // read side effects once, on the edge data is caught
   assign acc_o.rd   = req && !wb_we_i && !ack_r;
   assign acc_o.idx  = wb_adr_i[7:2];
   assign acc_o.wdat = wb_dat_i[7:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req && !ack_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= `TPI_RST_WORD;
      end else if (req && !ack_r) begin
         wb_dat_o <= {24'h00_0000, rd_data_i};
      end
   end
endmodule : tpi_wb_slave

// file: rtl/tpi_lvl_arb.sv
`timescale 1ns/1ps
`include "tpi_cfg.svh"
module tpi_lvl_arb
   import tpi_pkg::*;
#(
   parameter int              N      = `TPI_NSRC,
   parameter logic [N-1:0]    PERIPH = `TPI_PERIPH_MSK
)(
   // per-source bits
   input  wire logic [N-1:0] flag_i,
   input  wire logic [N-1:0] en_i,
   input  wire logic [N-1:0] prio_i,
   // global state
   input  wire logic         mode_i,
   input  wire logic         high_level_global_enable_i,
   input  wire logic         low_level_global_enable_i,
   input  wire logic         in_high_i,
   output tpi_req_t          req_o
);
   logic [N-1:0] hi_src;
   logic [N-1:0] lo_src;

   for (genvar i = 0; i < N; i++) begin : g_src
      logic pend;
      assign pend = flag_i[i] && en_i[i];
      // compat: priority ignored, peripherals also need bit 6
      assign hi_src[i] = mode_i ? pend && prio_i[i]
                                : pend && (!PERIPH[i] || low_level_global_enable_i);
      assign lo_src[i] = mode_i && pend && !prio_i[i];
   end

   assign req_o.hi  = high_level_global_enable_i && |hi_src;
   // low waits out any high routine
   assign req_o.lo  = high_level_global_enable_i && low_level_global_enable_i && |lo_src && !in_high_i;
   assign req_o.any = req_o.hi || req_o.lo;
endmodule : tpi_lvl_arb

// file: rtl/tpi_top.sv
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tpi_cfg.svh"
module tpi_top
   import tpi_pkg::*;
#(
   parameter int INSTR_DIV = `TPI_INSTR_DIV,
   parameter int IRQ_LAT   = `TPI_IRQ_LAT
)(
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic                      wb_ack_o,
   output logic [31:0]               wb_dat_o,
   // event sources
   input  wire logic                 timer0_ovf_i,
   input  wire logic                 ext_line0_i,
   input  wire logic [3:0]           port_b_upper_pins_i,
   input  wire logic [7:0]           periph_evt_i,
   // cpu core
   input  wire logic [`TPI_PC_W-1:0] pc_i,
   input  wire logic                 return_from_irq_i,
   output logic                      pc_load_o,
   output logic [`TPI_PC_W-1:0]      pc_val_o,
   output logic                      stack_push_o,
   output logic [`TPI_PC_W-1:0]      ret_addr_o,
   output logic                      in_high_isr_o,
   output logic                      in_low_isr_o
);
   localparam int DW = $clog2(INSTR_DIV + 1);
   localparam int LW = $clog2(IRQ_LAT + 1);

   tpi_acc_t              acc;
   tpi_req_t              req;
   tpi_state_t            st_r;
   tpi_state_t            st_nxt;
   logic [7:0]            rd_data;
   logic [DW-1:0]         div_cnt_r;
   logic [LW-1:0]         lat_r;
   logic                  q_en;
   logic                  high_level_global_enable_r;
   logic                  low_level_global_enable_r;
   logic                  t0ie_r;
   logic                  i0ie_r;
   logic                  port_b_change_irq_enable_r;
   logic                  t0if_r;
   logic                  i0if_r;
   logic                  port_b_change_irq_flag_r;
   logic                  mode_r;
   logic                  t0p_r;
   logic                  rbp_r;
   logic [7:0]            pfl_r;
   logic [7:0]            pen_r;
   logic [7:0]            ppr_r;
   logic [3:0]            pb_latch_r;
   logic                  in_hi_r;
   logic                  in_lo_r;
   logic                  vec_hi_r;
   logic [`TPI_PC_W-1:0]  ret_r;
   logic [`TPI_PC_W-1:0]  vec_r;
   logic                  take;
   logic                  mismatch;
   logic                  wr_ctrl;
   logic                  wr_reset_control_reg;
   logic                  wr_pflg;
   logic                  wr_pen;
   logic                  wr_ppri;
   logic                  wr_cpri;

   tpi_wb_slave u_wb (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .wb_cyc_i  (wb_cyc_i),
      .wb_stb_i  (wb_stb_i),
      .wb_we_i   (wb_we_i),
      .wb_adr_i  (wb_adr_i),
      .wb_sel_i  (wb_sel_i),
      .wb_dat_i  (wb_dat_i),
      .wb_ack_o  (wb_ack_o),
      .wb_dat_o  (wb_dat_o),
      .rd_data_i (rd_data),
      .acc_o     (acc)
   );

   tpi_lvl_arb #(
      .N      (`TPI_NSRC),
      .PERIPH (`TPI_PERIPH_MSK)
   ) u_arb (
      .flag_i    ({pfl_r, t0if_r, i0if_r, port_b_change_irq_flag_r}),
      .en_i      ({pen_r, t0ie_r, i0ie_r, port_b_change_irq_enable_r}),
      .prio_i    ({ppr_r, t0p_r, 1'b1, rbp_r}),
      .mode_i    (mode_r),
      .high_level_global_enable_i    (high_level_global_enable_r),
      .low_level_global_enable_i    (low_level_global_enable_r),
      .in_high_i (in_hi_r),
      .req_o     (req)
   );

   assign wr_ctrl  = acc.wr && acc.idx == `TPI_IDX_CTRL;
   assign wr_reset_control_reg  = acc.wr && acc.idx == `TPI_IDX_RESET_CONTROL_REG;
   assign wr_pflg  = acc.wr && acc.idx == `TPI_IDX_PFLG;
   assign wr_pen   = acc.wr && acc.idx == `TPI_IDX_PEN;
   assign wr_ppri  = acc.wr && acc.idx == `TPI_IDX_PPRI;
   assign wr_cpri  = acc.wr && acc.idx == `TPI_IDX_CPRI;
   assign take     = st_r == TPI_VECT;
   assign mismatch = port_b_upper_pins_i != pb_latch_r;

   // instruction-cycle enable
   assign q_en = div_cnt_r == DW'(INSTR_DIV - 1);

   always_ff @(posedge clk_i) begin
      if (rst_i || q_en) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_r + DW'(1);
      end
   end

   // global enables; a taken vector beats write and return
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         high_level_global_enable_r <= 1'b0;
         low_level_global_enable_r <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            high_level_global_enable_r <= acc.wdat[`TPI_B_HIGH_LEVEL_GLOBAL_ENABLE];
            low_level_global_enable_r <= acc.wdat[`TPI_B_LOW_LEVEL_GLOBAL_ENABLE];
         end
         if (return_from_irq_i) begin
            if (!mode_r || in_hi_r) begin
               high_level_global_enable_r <= 1'b1;
            end else begin
               low_level_global_enable_r <= 1'b1;
            end
         end
         if (take) begin
            if (vec_hi_r) begin
               high_level_global_enable_r <= 1'b0;
            end else begin
               low_level_global_enable_r <= 1'b0;
            end
         end
      end
   end

   // source enables and priority selects
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t0ie_r <= 1'b0;
         i0ie_r <= 1'b0;
         port_b_change_irq_enable_r <= 1'b0;
         pen_r  <= `TPI_RST_BYTE;
         ppr_r  <= `TPI_RST_BYTE;
         t0p_r  <= 1'b0;
         rbp_r  <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            t0ie_r <= acc.wdat[`TPI_B_T0IE];
            i0ie_r <= acc.wdat[`TPI_B_I0IE];
            port_b_change_irq_enable_r <= acc.wdat[`TPI_B_PORT_B_CHANGE_IRQ_ENABLE];
         end
         if (wr_pen) begin
            pen_r <= acc.wdat;
         end
         if (wr_ppri) begin
            ppr_r <= acc.wdat;
         end
         if (wr_cpri) begin
            t0p_r <= acc.wdat[`TPI_B_CPRI_T0];
            rbp_r <= acc.wdat[`TPI_B_CPRI_RB];
         end
      end
   end

   // priority mode is off after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= 1'b0;
      end else if (wr_reset_control_reg) begin
         mode_r <= acc.wdat[`TPI_B_MODE];
      end
   end

   // flags: hardware set wins over a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t0if_r <= 1'b0;
         i0if_r <= 1'b0;
         port_b_change_irq_flag_r <= 1'b0;
         pfl_r  <= `TPI_RST_BYTE;
      end else begin
         t0if_r <= (wr_ctrl ? acc.wdat[`TPI_B_T0IF] : t0if_r)
                   | timer0_ovf_i;
         i0if_r <= (wr_ctrl ? acc.wdat[`TPI_B_I0IF] : i0if_r)
                   | ext_line0_i;
         port_b_change_irq_flag_r <= (wr_ctrl ? acc.wdat[`TPI_B_PORT_B_CHANGE_IRQ_FLAG] : port_b_change_irq_flag_r)
                   | mismatch;
         pfl_r  <= (wr_pflg ? acc.wdat : pfl_r)
                   | periph_evt_i;
      end
   end

   // a port read ends the mismatch so the flag can clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pb_latch_r <= 4'h0;
      end else if (acc.rd && acc.idx == `TPI_IDX_PORT_B_INPUT_REG) begin
         pb_latch_r <= port_b_upper_pins_i;
      end
   end

   // which routines are running; high may nest over low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_hi_r <= 1'b0;
         in_lo_r <= 1'b0;
      end else if (take) begin
         if (vec_hi_r) begin
            in_hi_r <= 1'b1;
         end else begin
            in_lo_r <= 1'b1;
         end
      end else if (return_from_irq_i) begin
         if (in_hi_r) begin
            in_hi_r <= 1'b0;
         end else begin
            in_lo_r <= 1'b0;
         end
      end
   end

   // request seen at one instruction boundary, vector
   // after a fixed count, so latency is instruction-length blind
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         TPI_IDLE: begin
            if (q_en && req.any) begin
               st_nxt = TPI_WAIT;
            end
         end
         TPI_WAIT: begin
            if (!req.any) begin
               st_nxt = TPI_IDLE;
            end else if (q_en && lat_r == LW'(IRQ_LAT - 1)) begin
               st_nxt = TPI_VECT;
            end
         end
         TPI_VECT: begin
            st_nxt = TPI_IDLE;
         end
         default: begin
            st_nxt = TPI_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= TPI_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || st_r != TPI_WAIT) begin
         lat_r <= '0;
      end else if (q_en) begin
         lat_r <= lat_r + LW'(1);
      end
   end

   // level and address fixed on entry to the vector cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vec_hi_r <= 1'b0;
         vec_r    <= `TPI_VEC_HI;
         ret_r    <= '0;
      end else if (st_r == TPI_WAIT && st_nxt == TPI_VECT) begin
         vec_hi_r <= req.hi;
         vec_r    <= req.hi ? `TPI_VEC_HI : `TPI_VEC_LO;
         ret_r    <= pc_i;
      end
   end

   assign pc_load_o     = take;
   assign stack_push_o  = take;
   assign pc_val_o      = vec_r;
   assign ret_addr_o    = ret_r;
   assign in_high_isr_o = in_hi_r;
   assign in_low_isr_o  = in_lo_r;

   always_comb begin
      case (acc.idx)
         `TPI_IDX_CTRL:  rd_data = {high_level_global_enable_r, low_level_global_enable_r, t0ie_r, i0ie_r,
                                    port_b_change_irq_enable_r, t0if_r, i0if_r, port_b_change_irq_flag_r};
         `TPI_IDX_RESET_CONTROL_REG:  rd_data = {mode_r, 7'h00};
         `TPI_IDX_PFLG:  rd_data = pfl_r;
         `TPI_IDX_PEN:   rd_data = pen_r;
         `TPI_IDX_PPRI:  rd_data = ppr_r;
         `TPI_IDX_CPRI:  rd_data = {6'h00, t0p_r, rbp_r};
         `TPI_IDX_STAT:  rd_data = {2'h0, req.hi, req.lo, st_r,
                                    in_hi_r, in_lo_r};
         `TPI_IDX_PORT_B_INPUT_REG: rd_data = {4'h0, port_b_upper_pins_i};
         default:        rd_data = `TPI_RST_BYTE;
      endcase
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_hi_vector_addr: assert property (
      take && vec_hi_r |-> pc_val_o == `TPI_VEC_HI)
      else $error("high vector address wrong");

   chk_lo_vector_addr: assert property (
      take && !vec_hi_r |-> pc_val_o == `TPI_VEC_LO)
      else $error("low vector address wrong");

   chk_high_preempts_low: assert property (
      take && vec_hi_r && in_lo_r |=> in_hi_r && in_lo_r)
      else $error("high did not nest over low");

   chk_compat_single_vector: assert property (
      take && !mode_r && !$past(wr_reset_control_reg) |-> vec_hi_r)
      else $error("compat interrupt not at high vector");

   chk_enable_cleared: assert property (
      take && vec_hi_r |=> !high_level_global_enable_r)
      else $error("high enable not cleared on vector");

   chk_low_enable_cleared: assert property (
      take && !vec_hi_r |=> !low_level_global_enable_r)
      else $error("low enable not cleared on vector");

   chk_no_low_in_high: assert property (
      take && !vec_hi_r |-> !in_hi_r)
      else $error("low vector during high routine");

   chk_push_with_load: assert property (
      st_r == TPI_WAIT && st_nxt == TPI_VECT
      |=> stack_push_o && pc_load_o && ret_addr_o == $past(pc_i))
      else $error("return address not pushed");

   chk_return_reenables: assert property (
      return_from_irq_i && !take && !mode_r |=> high_level_global_enable_r)
      else $error("return did not re-enable");

   chk_latency_bound: assert property (
      $rose(st_r == TPI_WAIT) |-> ##[1:16] st_r != TPI_WAIT)
      else $error("vector latency too long");

   chk_flag_sets: assert property (
      (timer0_ovf_i |=> t0if_r) and (ext_line0_i |=> i0if_r))
      else $error("event flag not set");

   chk_port_mismatch: assert property (
      mismatch |=> port_b_change_irq_flag_r)
      else $error("port change flag not set");

   chk_high_first: assert property (
      st_r == TPI_WAIT && st_nxt == TPI_VECT && req.hi |=> vec_hi_r)
      else $error("low taken over pending high");
endmodule : tpi_top

// file: verif/tpi_cpu_model.sv
`timescale 1ns/1ps
`include "tpi_cfg.svh"
module tpi_cpu_model (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // interrupt unit side
   input  wire logic                 pc_load_i,
   input  wire logic [`TPI_PC_W-1:0] pc_val_i,
   input  wire logic                 push_i,
   input  wire logic [`TPI_PC_W-1:0] ret_addr_i,
   output logic      [`TPI_PC_W-1:0] pc_o,
   output logic                      ret_o,
   // bench side
   input  wire logic                 ret_req_i,
   output logic      [3:0]           depth_o
);
   logic [`TPI_PC_W-1:0] stack_r [0:7];

   // eight-deep stack, enough for two nested levels with margin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_o    <= 21'h0_0000;
         ret_o   <= 1'b0;
         depth_o <= 4'h0;
      end else begin
         ret_o <= ret_req_i;
         if (pc_load_i && push_i) begin
            stack_r[depth_o[2:0]] <= ret_addr_i;
            depth_o <= depth_o + 4'h1;
            pc_o    <= pc_val_i;
         end else if (ret_o && depth_o != 4'h0) begin
            pc_o    <= stack_r[depth_o[2:0] - 3'h1];
            depth_o <= depth_o - 4'h1;
         end else begin
            pc_o <= pc_o + 21'h0_0002;
         end
      end
   end
endmodule : tpi_cpu_model

// file: verif/tb_top.sv
`timescale 1ns/1ps
`include "tpi_cfg.svh"
`define TB_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
   $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end

module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic        t0 = 1'b0, l0 = 1'b0, ret_req = 1'b0;
   logic [3:0]  pins = 4'h0;
   logic [7:0]  pev = 8'h00;
   logic        wb_ack_o, pc_load_o, push, ret, in_hi, in_lo;
   logic [31:0] wb_dat_o;
   logic [20:0] pc_val_o, ret_addr, pc;
   logic [3:0]  depth;
   int          errors = 0, n_compared = 0, cycles = 0, n;

   tpi_top uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .timer0_ovf_i(t0),
      .ext_line0_i(l0), .port_b_upper_pins_i(pins), .periph_evt_i(pev),
      .pc_i(pc), .return_from_irq_i(ret), .pc_load_o(pc_load_o),
      .pc_val_o(pc_val_o), .stack_push_o(push), .ret_addr_o(ret_addr),
      .in_high_isr_o(in_hi), .in_low_isr_o(in_lo));

   tpi_cpu_model cpu (
      .clk_i(clk_i), .rst_i(rst_i), .pc_load_i(pc_load_o),
      .pc_val_i(pc_val_o), .push_i(push), .ret_addr_i(ret_addr),
      .pc_o(pc), .ret_o(ret), .ret_req_i(ret_req), .depth_o(depth));

   always #2.5 clk_i = ~clk_i;

   task tally_and_finish;
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish

   // the whole run needs a few hundred cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("Error at %0t: timeout", $time);
         tally_and_finish();
      end
   end

   task wb_acc(input logic w, input logic [7:0] a, input logic [7:0] d,
               output logic [7:0] q);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf;
      wdat <= {24'h00_0000, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o[7:0];
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask : wb_acc

   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb_acc(1'b1, a, d, q);
   endtask : wr

   task rd_exp(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb_acc(1'b0, a, 8'h00, q);
      `TB_CHK(q, e)
   endtask : rd_exp

   task pulse(input logic t, input logic l, input logic [7:0] p);
      @(posedge clk_i);
      t0 <= t; l0 <= l; pev <= p;
      @(posedge clk_i);
      t0 <= 1'b0; l0 <= 1'b0; pev <= 8'h00;
   endtask : pulse

   // n counts cycles since the event pulse, 0 if no vector came
   task wait_load(output int k);
      k = 0;
      for (int i = 1; i <= 40 && k == 0; i++) begin
         @(posedge clk_i);
         if (pc_load_o === 1'b1) k = i;
      end
   endtask : wait_load

   task expect_vec(input logic [20:0] a);
      int k;
      wait_load(k);
      `TB_CHK(k != 0, 1'b1)
      `TB_CHK(pc_val_o, a)
      // cpu pc has stepped once past the captured return address
      `TB_CHK(ret_addr, pc - 21'h0_0002)
      repeat (2) @(posedge clk_i);
   endtask : expect_vec

   task expect_none;
      int k;
      wait_load(k);
      `TB_CHK(k == 0, 1'b1)
   endtask : expect_none

   task do_ret;
      @(posedge clk_i);
      ret_req <= 1'b1;
      @(posedge clk_i);
      ret_req <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask : do_ret

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_exp(8'h04, 8'h00);
      rd_exp(8'h00, 8'h00);
      wr(8'h40, 8'hff);
      rd_exp(8'h40, 8'h00);
      pulse(1'b1, 1'b1, 8'h00);
      rd_exp(8'h00, 8'h06);
      wr(8'h00, 8'h00);
      rd_exp(8'h00, 8'h00);
      // port mismatch in compatibility mode
      pins <= 4'h5;
      rd_exp(8'h00, 8'h01);
      wr(8'h00, 8'h88);
      expect_vec(21'h0_0008);
      `TB_CHK(depth, 4'h1)
      rd_exp(8'h00, 8'h09);
      wr(8'h00, 8'h08);
      rd_exp(8'h00, 8'h09);
      rd_exp(8'h1c, 8'h05);
      wr(8'h00, 8'h08);
      rd_exp(8'h00, 8'h08);
      do_ret();
      `TB_CHK(depth, 4'h0)
      rd_exp(8'h00, 8'h88);
      // two-level mode, timer at low level, line0 preempts
      wr(8'h04, 8'h80);
      wr(8'h00, 8'he0);
      pulse(1'b1, 1'b0, 8'h00);
      expect_vec(21'h0_0018);
      `TB_CHK(in_lo, 1'b1)
      rd_exp(8'h00, 8'ha4);
      wr(8'h00, 8'hb0);
      pulse(1'b0, 1'b1, 8'h00);
      wait_load(n);
      `TB_CHK(n >= 13 && n <= 17, 1'b1)
      `TB_CHK(pc_val_o, 21'h0_0008)
      `TB_CHK(ret_addr, pc - 21'h0_0002)
      repeat (2) @(posedge clk_i);
      `TB_CHK(in_hi, 1'b1)
      rd_exp(8'h00, 8'h32);
      wr(8'h00, 8'he0);
      pulse(1'b1, 1'b0, 8'h00);
      expect_none();
      wr(8'h00, 8'h00);
      do_ret();
      `TB_CHK(in_hi, 1'b0)
      rd_exp(8'h00, 8'h80);
      do_ret();
      rd_exp(8'h00, 8'hc0);
      // both levels requested together
      wr(8'h00, 8'hf0);
      pulse(1'b1, 1'b1, 8'h00);
      expect_vec(21'h0_0008);
      wr(8'h00, 8'h00);
      do_ret();
      // compatibility mode ignores priority bits
      wr(8'h04, 8'h00);
      wr(8'h00, 8'ha0);
      pulse(1'b1, 1'b0, 8'h00);
      expect_vec(21'h0_0008);
      wr(8'h00, 8'h00);
      do_ret();
      rd_exp(8'h00, 8'h80);
      // peripheral source needs both enables in compatibility mode
      wr(8'h0c, 8'h01);
      pulse(1'b0, 1'b0, 8'h01);
      rd_exp(8'h08, 8'h01);
      wr(8'h00, 8'h80);
      expect_none();
      wr(8'h00, 8'h40);
      expect_none();
      wr(8'h00, 8'hc0);
      expect_vec(21'h0_0008);
      wr(8'h08, 8'h00);
      wr(8'h00, 8'h00);
      do_ret();
      rd_exp(8'h08, 8'h00);
      // priority selects: timer and peripheral moved to high level
      wr(8'h04, 8'h80);
      wr(8'h14, 8'h02);
      rd_exp(8'h14, 8'h02);
      wr(8'h10, 8'h01);
      rd_exp(8'h10, 8'h01);
      wr(8'h00, 8'ha0);
      pulse(1'b1, 1'b0, 8'h00);
      expect_vec(21'h0_0008);
      rd_exp(8'h18, 8'h02);
      wr(8'h00, 8'h00);
      do_ret();
      pulse(1'b0, 1'b0, 8'h01);
      expect_vec(21'h0_0008);
      wr(8'h08, 8'h00);
      wr(8'h00, 8'h00);
      do_ret();
      `TB_CHK(depth, 4'h0)
      tally_and_finish();
   end
endmodule : tb_top
